// ==== common/eoe_pkg.sv ====
// constants, field layout and enumerations for the external output evaluator
// Operation
// - above mode: output high while source exceeds the level, else low.
// - below mode: output high while source is under the level, else low.
// - inside mode: output high while source lies between its two bounds.
// - outside mode: output high while source lies outside the two bounds.
// - hysteresis offsets each threshold so on and off points differ.
// - a low-to-high request waits for the turn-on delay.
// - a high-to-low request waits for the turn-off delay.
// - once high, stay high at least the minimum high time.
// - once low, stay low at least the minimum low time.
// - active relay output with disabled mode sends zero.
// - linear type clamps the source to the input limits before mapping.
// - linear result is clamped to the output lower and upper limits.
// - input lower/upper limit maps linearly onto output lower/upper limit.
// - source error, over or under status gives the alarm value (linear).
// - undefined source, or all limits and the alarm value zero, sends zero (linear).
// - relay low encodes as zero, high as all ones of the register.
// - alarm reaction: no change, immediate low/high, or delayed low/high.
// - hysteresis band is centred on the level: level minus/plus hysteresis.
package eoe_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LEVEL = 8'h04;
    localparam logic [7:0] OFS_UPPER = 8'h08;
    localparam logic [7:0] OFS_HYST = 8'h0C;
    localparam logic [7:0] OFS_ON_DLY = 8'h10;
    localparam logic [7:0] OFS_OFF_DLY = 8'h14;
    localparam logic [7:0] OFS_MIN_ON = 8'h18;
    localparam logic [7:0] OFS_MIN_OFF = 8'h1C;
    localparam logic [7:0] OFS_IN_LO = 8'h20;
    localparam logic [7:0] OFS_IN_HI = 8'h24;
    localparam logic [7:0] OFS_OUT_LO = 8'h28;
    localparam logic [7:0] OFS_OUT_HI = 8'h2C;
    localparam logic [7:0] OFS_OUT_ALM = 8'h30;
    localparam logic [7:0] OFS_TICK_DIV = 8'h34;
    localparam logic [7:0] OFS_STATUS = 8'h38;
    localparam int NUM_CFG = 14;
    localparam int IDX_W = 4;
    // register indices (offset / 4)
    localparam logic [3:0] IX_CTRL = 4'h0;
    localparam logic [3:0] IX_LEVEL = 4'h1;
    localparam logic [3:0] IX_UPPER = 4'h2;
    localparam logic [3:0] IX_HYST = 4'h3;
    localparam logic [3:0] IX_ON_DLY = 4'h4;
    localparam logic [3:0] IX_OFF_DLY = 4'h5;
    localparam logic [3:0] IX_MIN_ON = 4'h6;
    localparam logic [3:0] IX_MIN_OFF = 4'h7;
    localparam logic [3:0] IX_IN_LO = 4'h8;
    localparam logic [3:0] IX_IN_HI = 4'h9;
    localparam logic [3:0] IX_OUT_LO = 4'hA;
    localparam logic [3:0] IX_OUT_HI = 4'hB;
    localparam logic [3:0] IX_OUT_ALM = 4'hC;
    localparam logic [3:0] IX_TICK_DIV = 4'hD;
    localparam logic [3:0] IX_STATUS = 4'hE;
    // control register fields
    localparam int CTRL_TYPE_BIT = 0;
    localparam int CTRL_ACTIVE_BIT = 1;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_ALARM_LSB = 8;
    // status register fields
    localparam int STAT_RELAY_BIT = 0;
    localparam int STAT_ALARM_BIT = 1;
    localparam int STAT_VALUE_LSB = 16;
    // reset values
    localparam logic [31:0] RST_CFG = 32'h0000_0000;
    // timebase: one tick per millisecond at a 4 ns clock
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // comparator modes
    typedef enum logic [2:0] {
        MODE_DISABLED = 3'd0,
        MODE_ABOVE = 3'd1,
        MODE_BELOW = 3'd2,
        MODE_INSIDE = 3'd3,
        MODE_OUTSIDE = 3'd4
    } eoe_mode_t;
    // alarm reactions
    typedef enum logic [2:0] {
        ALM_NO_CHANGE = 3'd0,
        ALM_IMM_OFF = 3'd1,
        ALM_IMM_ON = 3'd2,
        ALM_TIMED_OFF = 3'd3,
        ALM_TIMED_ON = 3'd4
    } eoe_alarm_t;
    // relay state, one-hot
    typedef enum logic [1:0] {
        RLY_LOW = 2'b01,
        RLY_HIGH = 2'b10
    } eoe_rly_t;
endpackage

// ==== hdl/eoe_timer.sv ====
// saturating interval counter advanced by the timebase tick
module eoe_timer #(
    parameter int W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clr,
    input wire logic tick,
    output logic [W-1:0] count
);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    // restart when the interval starts, saturate so long waits stay valid
    always_comb begin
        count_nxt = count_r;
        if (clr) begin
            count_nxt = '0;
        end else if (tick && count_r != {W{1'b1}}) begin
            count_nxt = count_r + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count = count_r;
endmodule

// ==== hdl/eoe_top.sv ====
// external output evaluator: relay and linear types behind axi4-lite
module eoe_top
    import eoe_pkg::*;
#(
    parameter int OUT_W = 16,
    parameter int TIME_W = 16,
    parameter int TICK_CYCLES_DEF = eoe_pkg::TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic signed [31:0] src_value,
    input wire logic src_defined,
    input wire logic src_error,
    input wire logic source_over_status,
    input wire logic source_under_status,
    output logic [OUT_W-1:0] ext_value,
    output logic relay_high
);
    import eoe_pkg::*;

    logic [31:0] cfg_r [NUM_CFG];
    logic [31:0] cfg_nxt [NUM_CFG];
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [31:0] tdiv_r, tdiv_nxt;
    logic tick;
    eoe_rly_t rly_r, rly_nxt;
    logic [OUT_W-1:0] val_r, val_nxt;
    logic [TIME_W-1:0] dly_cnt, hold_cnt;
    logic dly_clr, hold_clr;

    // configuration views
    logic is_linear, active, alarm, cur_high, req, cmp, force_en, force_val;
    logic go, cfg_zero;
    eoe_mode_t mode;
    eoe_alarm_t alm_sel;
    logic signed [33:0] v, lvl, upr, hys;
    logic [TIME_W-1:0] need_dly, need_hold;

    assign is_linear = cfg_r[IX_CTRL][CTRL_TYPE_BIT];
    assign active = cfg_r[IX_CTRL][CTRL_ACTIVE_BIT];
    assign mode = eoe_mode_t'(cfg_r[IX_CTRL][CTRL_MODE_LSB +: 3]);
    assign alm_sel = eoe_alarm_t'(cfg_r[IX_CTRL][CTRL_ALARM_LSB +: 3]);
    assign alarm = src_error | source_over_status | source_under_status;
    assign cur_high = (rly_r == RLY_HIGH);
    // widen by two bits so level plus or minus hysteresis cannot wrap
    assign v = 34'(src_value);
    assign lvl = 34'($signed(cfg_r[IX_LEVEL]));
    assign upr = 34'($signed(cfg_r[IX_UPPER]));
    assign hys = 34'($signed(cfg_r[IX_HYST]));

    // axi4-lite slave: address and data may arrive in either order
    always_comb begin
        logic [IDX_W-1:0] widx;
        logic [IDX_W-1:0] ridx;
        widx = awaddr_r[IDX_W+1:2];
        ridx = s_axi_araddr[IDX_W+1:2];
        cfg_nxt = cfg_r;
        aw_full_nxt = aw_full_r;
        w_full_nxt = w_full_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (aw_full_r && w_full_r && !bvalid_r) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_SLVERR;
            if (int'(widx) < NUM_CFG && awaddr_r[7:IDX_W+2] == '0) begin
                bresp_nxt = RESP_OKAY;
                for (int b = 0; b < 4; b++) begin
                    if (wstrb_r[b]) begin
                        cfg_nxt[widx][8*b +: 8] = wdata_r[8*b +: 8];
                    end
                end
            end
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            if (s_axi_araddr[7:IDX_W+2] != '0) begin
                rresp_nxt = RESP_SLVERR;
            end else if (ridx == IX_STATUS) begin
                rdata_nxt[STAT_RELAY_BIT] = cur_high;
                rdata_nxt[STAT_ALARM_BIT] = alarm;
                rdata_nxt[STAT_VALUE_LSB +: OUT_W] = val_r;
            end else if (int'(ridx) < NUM_CFG) begin
                rdata_nxt = cfg_r[ridx];
            end else begin
                rresp_nxt = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_CFG; i++) begin
                cfg_r[i] <= RST_CFG;
            end
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else begin
            cfg_r <= cfg_nxt;
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign s_axi_awready = !aw_full_r;
    assign s_axi_wready = !w_full_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    // timebase divider; a tick divider of 0 or 1 ticks every cycle
    always_comb begin
        tdiv_nxt = tdiv_r + 32'h0000_0001;
        tick = 1'b0;
        if (tdiv_r + 32'h0000_0001 >= cfg_r[IX_TICK_DIV]) begin
            tdiv_nxt = 32'h0000_0000;
            tick = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tdiv_r <= 32'h0000_0000;
        end else begin
            tdiv_r <= tdiv_nxt;
        end
    end

    // comparator; the band edges move with the present output state
    always_comb begin
        case (mode)
            MODE_ABOVE:
                cmp = cur_high ? (v > lvl - hys) : (v > lvl + hys);
            MODE_BELOW:
                cmp = cur_high ? (v < lvl + hys) : (v < lvl - hys);
            MODE_INSIDE:
                cmp = cur_high ? (v > lvl - hys && v < upr + hys)
                               : (v > lvl + hys && v < upr - hys);
            MODE_OUTSIDE:
                cmp = cur_high ? (v < lvl + hys || v > upr - hys)
                               : (v < lvl - hys || v > upr + hys);
            default:
                cmp = 1'b0;
        endcase
    end

    // alarm reaction picks the request or forces the state directly
    always_comb begin
        req = cmp;
        force_en = 1'b0;
        force_val = 1'b0;
        if (alarm) begin
            case (alm_sel)
                ALM_NO_CHANGE: req = cur_high;
                ALM_IMM_OFF: begin
                    force_en = 1'b1;
                    force_val = 1'b0;
                end
                ALM_IMM_ON: begin
                    force_en = 1'b1;
                    force_val = 1'b1;
                end
                ALM_TIMED_OFF: req = 1'b0;
                ALM_TIMED_ON: req = 1'b1;
                default: req = cmp;
            endcase
        end
    end

    // transition waits for its delay and for the minimum hold of the old state
    assign need_dly = cur_high ? cfg_r[IX_OFF_DLY][TIME_W-1:0]
                               : cfg_r[IX_ON_DLY][TIME_W-1:0];
    assign need_hold = cur_high ? cfg_r[IX_MIN_ON][TIME_W-1:0]
                                : cfg_r[IX_MIN_OFF][TIME_W-1:0];
    assign go = (req != cur_high) && dly_cnt >= need_dly
                && hold_cnt >= need_hold;

    always_comb begin
        rly_nxt = rly_r;
        case (rly_r)
            RLY_LOW: begin
                if (force_en ? force_val : go) begin
                    rly_nxt = RLY_HIGH;
                end
            end
            RLY_HIGH: begin
                if (force_en ? !force_val : go) begin
                    rly_nxt = RLY_LOW;
                end
            end
            default: rly_nxt = RLY_LOW;
        endcase
        // a disabled comparator parks the relay low
        if (mode == MODE_DISABLED || is_linear) begin
            rly_nxt = RLY_LOW;
        end
    end

    // delay restarts whenever no change is pending; hold restarts on a change
    // a forced state is no pending change, so no delay may build up under it
    assign dly_clr = force_en || (req == cur_high)
                     || (rly_nxt != rly_r);
    assign hold_clr = (rly_nxt != rly_r);

    eoe_timer #(.W(TIME_W)) u_dly (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr(dly_clr),
        .tick(tick),
        .count(dly_cnt)
    );

    eoe_timer #(.W(TIME_W)) u_hold (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr(hold_clr),
        .tick(tick),
        .count(hold_cnt)
    );

    // linear mapping in 64-bit signed arithmetic, clamped at both ends
    always_comb begin
        logic signed [63:0] ilo, ihi, olo, ohi, xc, num, den, y, omin, omax;
        ilo = 64'($signed(cfg_r[IX_IN_LO]));
        ihi = 64'($signed(cfg_r[IX_IN_HI]));
        olo = 64'(cfg_r[IX_OUT_LO][OUT_W-1:0]);
        ohi = 64'(cfg_r[IX_OUT_HI][OUT_W-1:0]);
        xc = 64'(src_value);
        if (xc < ilo) xc = ilo;
        if (xc > ihi) xc = ihi;
        den = ihi - ilo;
        num = (xc - ilo) * (ohi - olo);
        y = (den == 0) ? olo : olo + num / den;
        omin = (olo < ohi) ? olo : ohi;
        omax = (olo < ohi) ? ohi : olo;
        if (y < omin) y = omin;
        if (y > omax) y = omax;
        cfg_zero = cfg_r[IX_IN_LO] == 32'h0000_0000
                   && cfg_r[IX_IN_HI] == 32'h0000_0000
                   && cfg_r[IX_OUT_LO] == 32'h0000_0000
                   && cfg_r[IX_OUT_HI] == 32'h0000_0000
                   && cfg_r[IX_OUT_ALM] == 32'h0000_0000;
        val_nxt = '0;
        if (!active) begin
            val_nxt = '0;
        end else if (!is_linear) begin
            if (mode != MODE_DISABLED && cur_high) begin
                val_nxt = {OUT_W{1'b1}};
            end else begin
                val_nxt = '0;
            end
        end else if (!src_defined || cfg_zero) begin
            val_nxt = '0;
        end else if (alarm) begin
            val_nxt = cfg_r[IX_OUT_ALM][OUT_W-1:0];
        end else begin
            val_nxt = y[OUT_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rly_r <= RLY_LOW;
            val_r <= '0;
        end else begin
            rly_r <= rly_nxt;
            val_r <= val_nxt;
        end
    end

    assign ext_value = val_r;
    assign relay_high = cur_high;

    // checks on the relay and linear paths
    a_disabled_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        active && !is_linear && mode == MODE_DISABLED |=> ext_value == '0)
        else $error("disabled relay output not zero");
    a_high_encode: assert property (@(posedge aclk) disable iff (!aresetn)
        active && !is_linear && mode != MODE_DISABLED && relay_high
        |=> ext_value == {OUT_W{1'b1}})
        else $error("relay high not all ones");
    a_imm_off: assert property (@(posedge aclk) disable iff (!aresetn)
        alarm && alm_sel == ALM_IMM_OFF |=> !relay_high)
        else $error("immediate off not applied");
    a_imm_on: assert property (@(posedge aclk) disable iff (!aresetn)
        alarm && alm_sel == ALM_IMM_ON && mode != MODE_DISABLED && !is_linear
        |=> relay_high)
        else $error("immediate on not applied");
    a_on_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        !relay_high && rly_nxt == RLY_HIGH && !force_en
        |-> dly_cnt >= cfg_r[IX_ON_DLY][TIME_W-1:0]
            && hold_cnt >= cfg_r[IX_MIN_OFF][TIME_W-1:0])
        else $error("rise before on delay or min low");
    a_off_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        relay_high && rly_nxt == RLY_LOW && !force_en
        && mode != MODE_DISABLED && !is_linear
        |-> dly_cnt >= cfg_r[IX_OFF_DLY][TIME_W-1:0]
            && hold_cnt >= cfg_r[IX_MIN_ON][TIME_W-1:0])
        else $error("fall before off delay or min high");
    a_lin_alarm: assert property (@(posedge aclk) disable iff (!aresetn)
        active && is_linear && src_defined && !cfg_zero && alarm
        |=> ext_value == $past(cfg_r[IX_OUT_ALM][OUT_W-1:0]))
        else $error("alarm value not sent");
    a_lin_undef: assert property (@(posedge aclk) disable iff (!aresetn)
        active && is_linear && !src_defined |=> ext_value == '0)
        else $error("undefined source not zero");
    a_lin_span: assert property (@(posedge aclk) disable iff (!aresetn)
        active && is_linear && src_defined && !cfg_zero && !alarm
        && cfg_r[IX_OUT_LO][OUT_W-1:0] <= cfg_r[IX_OUT_HI][OUT_W-1:0]
        |=> ext_value >= $past(cfg_r[IX_OUT_LO][OUT_W-1:0])
            && ext_value <= $past(cfg_r[IX_OUT_HI][OUT_W-1:0]))
        else $error("linear value outside output limits");
endmodule

// ==== testbench/eoe_slave_model.sv ====
// stand-in for the modbus slave: holds the last output register value
module eoe_slave_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] reg_in,
    output logic [15:0] holding_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    // the slave only sees what was sent, one cycle late, cleared on reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            holding_reg <= 16'h0000;
        end else begin
            holding_reg <= reg_in;
        end
    end
endmodule

// ==== testbench/external_output_evaluator_tb_top.sv ====
// self-checking bench for the external output evaluator
module external_output_evaluator_tb_top;
    import eoe_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
        miscompares++; \
        $display("wrong value %s exp %0h got %0h", n, e, g); end end
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, d, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid;
    logic arready, rvalid, relay_high;
    logic [1:0] bresp, rresp, r;
    logic signed [31:0] src_value = 32'h0000_0000;
    logic src_defined = 1'b1, src_error = 1'b0;
    logic over_st = 1'b0, under_st = 1'b0;
    logic [15:0] ext_value, slave_val;
    int seed = 32'h91a6;
    int num_checks = 0;
    int miscompares = 0;
    int v;
    int hv[10] = '{105, 111, 95, 90, 105, 95, 89, 105, 110, 95};
    bit he[10] = '{0, 1, 1, 0, 0, 0, 1, 1, 0, 0};

    // 250 MHz clock
    always #2 aclk = ~aclk;

    eoe_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .src_value(src_value),
        .src_defined(src_defined), .src_error(src_error),
        .source_over_status(over_st), .source_under_status(under_st),
        .ext_value(ext_value), .relay_high(relay_high));
    eoe_slave_model u_slave (.aclk(aclk), .aresetn(aresetn),
        .reg_in(ext_value), .holding_reg(slave_val));

    // write with address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] dv);
        awaddr <= a;
        wdata <= dv;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!awready);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!wready);
                wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        // let an edge pass so a following call never reassigns bready
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    // settle time covers input, relay, output and slave register stages
    task automatic setv(input int x);
        src_value <= x;
        repeat (6) @(posedge aclk);
    endtask
    task automatic chk_rly(input bit e);
        `CHK("relay", e, relay_high)
        `CHK("slave", e ? 16'hffff : 16'h0000, slave_val)
    endtask
    function automatic logic [31:0] cw(int t, int m, int a);
        return 32'(t + 2 + m * 16 + a * 256);
    endfunction
    // comparator model with level -50, upper 50, no hysteresis
    function automatic bit cmp(int m, int x);
        case (m)
            1: return x > -50;
            2: return x < -50;
            3: return x > -50 && x < 50;
            4: return x < -50 || x > 50;
            default: return 1'b0;
        endcase
    endfunction
    // linear model: input -1000..1000 onto output 100..40100
    function automatic logic [15:0] lin(int x);
        int c;
        c = x < -1000 ? -1000 : (x > 1000 ? 1000 : x);
        return 16'(100 + (c + 1000) * 40000 / 2000);
    endfunction
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(OFS_CTRL);
        `CHK("ctrl reset", RST_CFG, d)
        rd(8'h3c);
        `CHK("rresp unmapped", RESP_SLVERR, r)
        wr(8'h40, 32'h0000_0001);
        `CHK("bresp unmapped", RESP_SLVERR, r)
        wr(OFS_STATUS, 32'h0000_0001);
        `CHK("bresp status", RESP_SLVERR, r)
        // hysteresis walk: above then below, level 100, band 10
        wr(OFS_LEVEL, 32'd100);
        wr(OFS_HYST, 32'd10);
        for (int i = 0; i < 10; i++) begin
            if (i % 5 == 0) wr(OFS_CTRL, cw(0, i < 5 ? 1 : 2, 0));
            setv(hv[i]);
            chk_rly(he[i]);
        end
        // every mode, disabled included, with random odd values
        wr(OFS_LEVEL, -32'sd50);
        wr(OFS_UPPER, 32'd50);
        wr(OFS_HYST, 32'd0);
        for (int m = 0; m < 5; m++) begin
            wr(OFS_CTRL, cw(0, m, 0));
            repeat (6) begin
                v = 2 * ($random(seed) % 150) + 1;
                setv(v);
                chk_rly(cmp(m, v));
            end
        end
        // turn-on delay then minimum high time, level 0, one tick per cycle
        wr(OFS_LEVEL, 32'd0);
        setv(-10);
        wr(OFS_CTRL, cw(0, 1, 0));
        wr(OFS_ON_DLY, 32'd5);
        wr(OFS_MIN_ON, 32'd20);
        setv(-10);
        src_value <= 10;
        // five ticks of delay: the relay may rise at the sixth edge only
        repeat (5) @(posedge aclk);
        `CHK("on delay", 1'b0, relay_high)
        repeat (2) @(posedge aclk);
        `CHK("after delay", 1'b1, relay_high)
        rd(OFS_STATUS);
        `CHK("status", 17'h1_ffff, {d[31:16], d[0]})
        setv(-10);
        `CHK("min high", 1'b1, relay_high)
        repeat (30) @(posedge aclk);
        chk_rly(1'b0);
        // immediate alarm reactions override the comparator
        wr(OFS_ON_DLY, 32'd0);
        wr(OFS_MIN_ON, 32'd0);
        wr(OFS_CTRL, cw(0, 1, 2));
        src_error <= 1'b1;
        setv(-10);
        chk_rly(1'b1);
        wr(OFS_CTRL, cw(0, 1, 1));
        setv(10);
        chk_rly(1'b0);
        // timed reactions wait for their delays; no change freezes the relay
        wr(OFS_ON_DLY, 32'd4);
        wr(OFS_OFF_DLY, 32'd4);
        wr(OFS_CTRL, cw(0, 2, 4));
        repeat (2) @(posedge aclk);
        `CHK("timed on early", 1'b0, relay_high)
        setv(10);
        chk_rly(1'b1);
        wr(OFS_CTRL, cw(0, 2, 0));
        setv(10);
        chk_rly(1'b1);
        wr(OFS_CTRL, cw(0, 2, 3));
        repeat (2) @(posedge aclk);
        `CHK("timed off early", 1'b1, relay_high)
        setv(10);
        chk_rly(1'b0);
        src_error <= 1'b0;
        // linear type: clamp and map, then alarm and undefined source
        wr(OFS_IN_LO, -32'sd1000);
        wr(OFS_IN_HI, 32'd1000);
        wr(OFS_OUT_LO, 32'd100);
        wr(OFS_OUT_HI, 32'd40100);
        wr(OFS_OUT_ALM, 32'h0000_1234);
        wr(OFS_CTRL, cw(1, 0, 0));
        repeat (10) begin
            v = $random(seed) % 1500;
            setv(v);
            `CHK("linear", lin(v), slave_val)
        end
        for (int k = 0; k < 3; k++) begin
            {src_error, over_st, under_st} <= 3'(1 << k);
            setv(v);
            `CHK("alarm value", 16'h1234, slave_val)
        end
        {src_error, over_st, under_st} <= 3'b000;
        src_defined <= 1'b0;
        setv(v);
        `CHK("undefined", 16'h0000, slave_val)
        end_of_test();
    end
endmodule
